// >>> adc_map.vh
/*
 Register map, field positions, reset values and timing counts of the
 converter register interface. Assumes a 32-bit APB address bus.
*/
// Summary of operation
// - Status holds only done flag, bit 0
// - Conversion end sets flag, raises interrupt
// - Reading result data clears done flag
// - Active output high during a conversion
// - Active output low once conversion finishes
// - Active also on P0.2 when routed
// - Result register holds latest 12-bit result
// - Reset register write restores converter defaults
// - Gain calibration applies to non-amplified channels
// - Offset calibration applies to every channel
// - One register sets both front amp gains
// - Control at 0xffff0500, resets to 0x00000a00
// - Control: enable, input mode, trigger type
// - Bits 2:0 select the conversion trigger
// - Single software trigger reverts to 000 after
// - Clock divider, acquisition time, 19 bit clocks
`ifndef ADC_MAP_VH
`define ADC_MAP_VH

`define CONTROL_ADDR      32'hffff0500
`define POS_CHAN_ADDR     32'hffff0504
`define NEG_CHAN_ADDR     32'hffff0508
`define STATUS_ADDR       32'hffff050c
`define RESULT_ADDR       32'hffff0510
`define REG_RESET_ADDR    32'hffff0514
`define GAIN_CAL_ADDR     32'hffff0518
`define OFFSET_CAL_ADDR   32'hffff051c
`define AMP_GAIN_ADDR     32'hffff0520
`define GPIO_CFG_ADDR     32'hffff0524
`define IRQ_STATUS_ADDR   32'hffff0528
`define IRQ_CLEAR_ADDR    32'hffff052c
`define IRQ_ENABLE_ADDR   32'hffff0530

`define CONTROL_RESET     16'h0a00
`define CONTROL_WMASK     16'hffbf
`define GAIN_CAL_RESET    16'h8000
`define IRQ_ENABLE_RESET  2'h1

`define TRIG_LSB          0
`define MODE_LSB          3
`define POWER_BIT         5
`define ENABLE_BIT        7
`define ACQ_LSB           8
`define DIV_LSB           11

`define TRIG_EXT_PIN      3'h0
`define TRIG_TIMER1       3'h1
`define TRIG_TIMER0       3'h2
`define TRIG_SW_SINGLE    3'h3
`define TRIG_SW_CONT      3'h4
`define TRIG_LOGIC        3'h5
`define TRIG_PWM          3'h6
`define MODE_DIFF         2'h1

`define CHAN_AMP_PAIR0    5'h00
`define CHAN_AMP_PAIR1    5'h01
`define CHAN_TEMP         5'h0d
`define TEMP_ACQ_CODE     3'h3
`define TEMP_DIV_CODE     3'h5

`define BIT_TRIAL_CLOCKS  7'd19
`define GPIO_BUSY_BIT     0
`define IRQ_DONE_BIT      0
`define IRQ_OVERRUN_BIT   1

`endif

// >>> adc_regs.v
/*
 APB register interface and conversion sequencer of the 12-bit SAR
 converter. Assumes the analog core presents a stable raw code on
 sample_code by the end of the bit-trial phase, and that timer, logic
 array and PWM triggers are one-cycle pulses on pclk.
*/
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.vh"
module adc_regs (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        convst_pin,
   input  wire        timer0_evt,
   input  wire        timer1_evt,
   input  wire        logic_evt,
   input  wire        pwm_evt,
   input  wire [11:0] sample_code,
   output reg         sample_hold_r,
   output reg  [15:0] converter_control_r,
   output reg  [4:0]  positive_channel_select_r,
   output reg  [4:0]  negative_channel_select_r,
   output reg  [4:0]  front_amp_pair_zero_r,
   output reg  [4:0]  front_amp_pair_one_r,
   output reg         conversion_active_output_r,
   output reg         p0_2_r,
   output reg         irq_r
);
   localparam ST_IDLE = 2'b00;
   localparam ST_ACQ  = 2'b01;
   localparam ST_CONV = 2'b10;
   localparam ST_CAL  = 2'b11;

   // Address decode, shared by the read and write paths
   function [3:0] reg_sel;
      input [31:0] a;
      begin
         case (a)
            `CONTROL_ADDR:    reg_sel = 4'h0;
            `POS_CHAN_ADDR:   reg_sel = 4'h1;
            `NEG_CHAN_ADDR:   reg_sel = 4'h2;
            `STATUS_ADDR:     reg_sel = 4'h3;
            `RESULT_ADDR:     reg_sel = 4'h4;
            `REG_RESET_ADDR:  reg_sel = 4'h5;
            `GAIN_CAL_ADDR:   reg_sel = 4'h6;
            `OFFSET_CAL_ADDR: reg_sel = 4'h7;
            `AMP_GAIN_ADDR:   reg_sel = 4'h8;
            `GPIO_CFG_ADDR:   reg_sel = 4'h9;
            `IRQ_STATUS_ADDR: reg_sel = 4'ha;
            `IRQ_CLEAR_ADDR:  reg_sel = 4'hb;
            `IRQ_ENABLE_ADDR: reg_sel = 4'hc;
            default:          reg_sel = 4'hf;
         endcase
      end
   endfunction

   reg  [1:0]  state_r;
   reg  [6:0]  cnt_r;
   reg  [4:0]  pre_r;
   reg  [2:0]  eff_div_r;
   reg         sw_go_r;
   reg         done_r;
   reg         overrun_r;
   reg  [11:0] result_r;
   reg         result_diff_r;
   reg  [15:0] gain_cal_r;
   reg  [11:0] offset_cal_r;
   reg         gpio_cfg_r;
   reg  [1:0]  irq_en_r;
   reg         cv_s1;
   reg         cv_s2;
   reg         cv_s3;
   reg         cal_start_r;
   reg         trig_hit;
   reg  [31:0] rd_mux;
   wire        cal_valid;
   wire [11:0] cal_result;

   wire        setup    = psel & ~penable;
   wire        access   = psel & penable & pready;
   wire [3:0]  sel      = reg_sel(paddr);
   wire        wr       = access & pwrite;
   wire        rd       = access & ~pwrite;
   wire        wr_ctrl  = wr & (sel == 4'h0);
   wire        rst_wr   = wr & (sel == 4'h5);
   wire        iclr_wr  = wr & (sel == 4'hb);
   wire        res_rd   = rd & (sel == 4'h4);

   wire [2:0]  trig     = converter_control_r[`TRIG_LSB +: 3];
   wire [1:0]  mode     = converter_control_r[`MODE_LSB +: 2];
   wire [2:0]  acq_code = converter_control_r[`ACQ_LSB +: 3];
   wire [2:0]  div_code = converter_control_r[`DIV_LSB +: 3];
   wire        conv_on  = converter_control_r[`ENABLE_BIT] &
                          converter_control_r[`POWER_BIT];
   wire        temp_ch  = positive_channel_select_r == `CHAN_TEMP;
   wire        amp_ch   = (positive_channel_select_r == `CHAN_AMP_PAIR0) |
                          (positive_channel_select_r == `CHAN_AMP_PAIR1);
   wire        ext_edge = cv_s2 & ~cv_s3;
   wire        idle     = state_r == ST_IDLE;
   wire        go       = conv_on & trig_hit & idle & ~rst_wr;
   wire        overrun  = conv_on & trig_hit & ~idle & (trig != `TRIG_SW_CONT);

   // Converter clock enable: divide by 2**code, by 32 for codes 6 and 7
   wire [4:0]  div_max  = (5'h01 << eff_div_r) - 5'h01;
   wire        adc_ce   = pre_r == div_max;
   wire [2:0]  acq_eff  = temp_ch ? `TEMP_ACQ_CODE : acq_code;
   wire [6:0]  acq_clks = 7'h02 << acq_eff;
   wire        last     = adc_ce & (cnt_r == 7'h01);
   wire        conv_end = (state_r == ST_CONV) & last;
   wire        done_set = cal_valid & ~rst_wr;

   // Trigger source selection
   always @* begin
      case (trig)
         `TRIG_EXT_PIN:   trig_hit = ext_edge;
         `TRIG_TIMER1:    trig_hit = timer1_evt;
         `TRIG_TIMER0:    trig_hit = timer0_evt;
         `TRIG_SW_SINGLE: trig_hit = sw_go_r;
         `TRIG_SW_CONT:   trig_hit = 1'b1;
         `TRIG_LOGIC:     trig_hit = logic_evt;
         `TRIG_PWM:       trig_hit = pwm_evt;
         default:         trig_hit = 1'b0;
      endcase
   end

   always @* begin
      case (sel)
         4'h0:    rd_mux = {16'h0000, converter_control_r};
         4'h1:    rd_mux = {27'h0, positive_channel_select_r};
         4'h2:    rd_mux = {27'h0, negative_channel_select_r};
         4'h3:    rd_mux = {31'h0, done_r};
         4'h4:    rd_mux = {{4{result_diff_r & result_r[11]}}, result_r, 16'h0000};
         4'h6:    rd_mux = {16'h0000, gain_cal_r};
         4'h7:    rd_mux = {20'h0, offset_cal_r};
         4'h8:    rd_mux = {22'h0, front_amp_pair_one_r, front_amp_pair_zero_r};
         4'h9:    rd_mux = {31'h0, gpio_cfg_r};
         4'ha:    rd_mux = {30'h0, overrun_r, done_r};
         4'hc:    rd_mux = {30'h0, irq_en_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // APB answer: registered at setup, one access cycle, no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= sel == 4'hf;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // External convert-start pin synchroniser
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cv_s1 <= 1'b0;
         cv_s2 <= 1'b0;
         cv_s3 <= 1'b0;
      end else begin
         cv_s1 <= convst_pin;
         cv_s2 <= cv_s1;
         cv_s3 <= cv_s2;
      end
   end

   // Software-writable configuration
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_control_r       <= `CONTROL_RESET;
         positive_channel_select_r <= 5'h00;
         negative_channel_select_r <= 5'h00;
         front_amp_pair_zero_r     <= 5'h00;
         front_amp_pair_one_r      <= 5'h00;
         gain_cal_r                <= `GAIN_CAL_RESET;
         offset_cal_r              <= 12'h000;
         gpio_cfg_r                <= 1'b0;
         irq_en_r                  <= `IRQ_ENABLE_RESET;
         sw_go_r                   <= 1'b0;
      end else if (rst_wr) begin
         converter_control_r       <= `CONTROL_RESET;
         positive_channel_select_r <= 5'h00;
         negative_channel_select_r <= 5'h00;
         front_amp_pair_zero_r     <= 5'h00;
         front_amp_pair_one_r      <= 5'h00;
         gain_cal_r                <= `GAIN_CAL_RESET;
         offset_cal_r              <= 12'h000;
         sw_go_r                   <= 1'b0;
      end else begin
         if (go)
            sw_go_r <= 1'b0;
         // Single software conversion reverts to pin trigger
         if (cal_valid && trig == `TRIG_SW_SINGLE)
            converter_control_r[`TRIG_LSB +: 3] <= `TRIG_EXT_PIN;
         if (wr_ctrl) begin
            converter_control_r <= pwdata[15:0] & `CONTROL_WMASK;
            sw_go_r <= pwdata[`TRIG_LSB +: 3] == `TRIG_SW_SINGLE;
         end
         if (wr && sel == 4'h1)
            positive_channel_select_r <= pwdata[4:0];
         if (wr && sel == 4'h2)
            negative_channel_select_r <= pwdata[4:0];
         if (wr && sel == 4'h6)
            gain_cal_r <= pwdata[15:0];
         if (wr && sel == 4'h7)
            offset_cal_r <= pwdata[11:0];
         if (wr && sel == 4'h8) begin
            front_amp_pair_zero_r <= pwdata[4:0];
            front_amp_pair_one_r  <= pwdata[9:5];
         end
         if (wr && sel == 4'h9)
            gpio_cfg_r <= pwdata[`GPIO_BUSY_BIT];
         if (wr && sel == 4'hc)
            irq_en_r <= pwdata[1:0];
      end
   end

   // Conversion sequencer: acquisition, bit trials, calibration
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r       <= ST_IDLE;
         cnt_r         <= 7'h00;
         pre_r         <= 5'h00;
         eff_div_r     <= 3'h0;
         cal_start_r   <= 1'b0;
         sample_hold_r <= 1'b0;
      end else begin
         cal_start_r <= 1'b0;
         pre_r <= adc_ce ? 5'h00 : pre_r + 5'h01;
         if (rst_wr || !conv_on) begin
            state_r       <= ST_IDLE;
            sample_hold_r <= 1'b0;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  if (go) begin
                     state_r       <= ST_ACQ;
                     cnt_r         <= acq_clks;
                     pre_r         <= 5'h00;
                     eff_div_r     <= temp_ch ? `TEMP_DIV_CODE : div_code;
                     sample_hold_r <= 1'b1;
                  end
               end
               ST_ACQ: begin
                  if (adc_ce)
                     cnt_r <= cnt_r - 7'h01;
                  if (last) begin
                     state_r       <= ST_CONV;
                     cnt_r         <= `BIT_TRIAL_CLOCKS;
                     sample_hold_r <= 1'b0;
                  end
               end
               ST_CONV: begin
                  if (adc_ce)
                     cnt_r <= cnt_r - 7'h01;
                  if (last) begin
                     state_r     <= ST_CAL;
                     cal_start_r <= 1'b1;
                  end
               end
               ST_CAL: begin
                  if (cal_valid)
                     state_r <= ST_IDLE;
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Conversion-active pin and its optional GPIO copy
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_active_output_r <= 1'b0;
         p0_2_r                     <= 1'b0;
      end else begin
         if (go)
            conversion_active_output_r <= 1'b1;
         if (conv_end || rst_wr || !conv_on)
            conversion_active_output_r <= 1'b0;
         p0_2_r <= gpio_cfg_r & (go | (conversion_active_output_r &
                   ~(conv_end | rst_wr | ~conv_on)));
      end
   end

   // Result, done flag, overrun and interrupt; a set beats a clear except a reset-register write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_r      <= 12'h000;
         result_diff_r <= 1'b0;
         done_r        <= 1'b0;
         overrun_r     <= 1'b0;
         irq_r         <= 1'b0;
      end else begin
         if (rst_wr) begin
            result_r      <= 12'h000;
            result_diff_r <= 1'b0;
         end else if (cal_valid) begin
            result_r      <= cal_result;
            result_diff_r <= mode == `MODE_DIFF;
         end
         if (res_rd || rst_wr || (iclr_wr && pwdata[`IRQ_DONE_BIT]))
            done_r <= 1'b0;
         if (done_set)
            done_r <= 1'b1;
         if (iclr_wr && pwdata[`IRQ_OVERRUN_BIT])
            overrun_r <= 1'b0;
         if (overrun)
            overrun_r <= 1'b1;
         irq_r <= (irq_en_r[`IRQ_DONE_BIT] & (done_set |
                   (done_r & ~res_rd & ~rst_wr &
                   ~(iclr_wr & pwdata[`IRQ_DONE_BIT])))) |
                  (irq_en_r[`IRQ_OVERRUN_BIT] & (overrun |
                   (overrun_r & ~(iclr_wr & pwdata[`IRQ_OVERRUN_BIT]))));
      end
   end

   cal_unit u_cal (
      .clk        (pclk),
      .rst_n      (presetn),
      .start      (cal_start_r),
      .raw        (sample_code),
      .diff_mode  (mode == `MODE_DIFF),
      .apply_gain (~amp_ch),
      .gain       (gain_cal_r),
      .offset     (offset_cal_r),
      .valid_r    (cal_valid),
      .result_r   (cal_result)
   );
endmodule // adc_regs
`default_nettype wire

// >>> adc_regs_sva.sv
/*
 Checker for the converter register interface: APB timing, status and
 result layout, interrupt and conversion-active behaviour.
 Assumes it is bound to adc_regs and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.vh"
module adc_regs_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sample_hold_r,
   input wire logic [15:0] converter_control_r,
   input wire logic        conversion_active_output_r,
   input wire logic        p0_2_r,
   input wire logic        irq_r
);
   logic rd;
   logic mapped;
   assign rd = pready && psel && penable && !pwrite;
   assign mapped = paddr[1:0] == 2'h0 && paddr >= `CONTROL_ADDR && paddr <= `IRQ_ENABLE_ADDR;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
      else $error("no answer one cycle after setup");
   a_error_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("error response does not match address map");
   a_status_bits: assert property (rd && paddr == `STATUS_ADDR |-> prdata[31:1] == 31'h0)
      else $error("status register upper bits not zero");
   a_read_clears_irq: assert property (rd && paddr == `RESULT_ADDR |-> ##2 !irq_r)
      else $error("interrupt still high after result read");
   a_irq_after_conv: assert property ($rose(irq_r) |->
      $past(conversion_active_output_r, 3) || $past(conversion_active_output_r, 4)
      || $past(conversion_active_output_r, 5))
      else $error("interrupt rose without a finished conversion");
   a_pin_copy: assert property (p0_2_r |-> conversion_active_output_r
      || $past(conversion_active_output_r))
      else $error("port bit high outside a conversion");
   a_hold_in_active: assert property (sample_hold_r |-> conversion_active_output_r)
      else $error("acquisition outside conversion-active");
   a_active_min: assert property ($rose(conversion_active_output_r) |->
      conversion_active_output_r[*8])
      else $error("conversion-active dropped too early");
   a_ctrl_reserved: assert property (rd && paddr == `CONTROL_ADDR |->
      prdata[31:16] == 16'h0 && !prdata[6])
      else $error("control reserved bits not zero");
   a_result_layout: assert property (rd && paddr == `RESULT_ADDR &&
      converter_control_r[4:3] != `MODE_DIFF |-> prdata[31:28] == 4'h0 && prdata[15:0] == 16'h0)
      else $error("result word layout wrong");
   c_irq: cover property ($rose(irq_r));
   c_err: cover property (pready && pslverr);
   c_pin: cover property ($rose(p0_2_r));
endmodule // adc_regs_sva
bind adc_regs adc_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_hold_r(sample_hold_r), .converter_control_r(converter_control_r),
   .conversion_active_output_r(conversion_active_output_r), .p0_2_r(p0_2_r), .irq_r(irq_r));
`default_nettype wire

// >>> cal_unit.v
/*
 Calibration datapath: scales a raw code by the gain word, adds the
 signed offset and clips to the 12-bit range of the active coding.
 Assumes raw is stable on the cycle that start is high.
*/
`timescale 1ns/1ps
`default_nettype none
module cal_unit (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        start,
   input  wire [11:0] raw,
   input  wire        diff_mode,
   input  wire        apply_gain,
   input  wire [15:0] gain,
   input  wire [11:0] offset,
   output reg         valid_r,
   output reg  [11:0] result_r
);
   wire signed [12:0] raw_s;
   wire signed [16:0] gain_s;
   wire signed [29:0] prod;
   wire signed [14:0] scaled;
   wire signed [15:0] sum;
   reg         [11:0] clip;

   assign raw_s  = diff_mode ? {raw[11], raw} : {1'b0, raw};
   // Unity gain for amplified channels
   assign gain_s = apply_gain ? {1'b0, gain} : 17'sh08000;
   assign prod   = raw_s * gain_s;
   assign scaled = prod[29:15];
   assign sum    = {scaled[14], scaled} + {{4{offset[11]}}, offset};

   always @* begin
      clip = sum[11:0];
      if (diff_mode) begin
         if (sum > 16'sh07ff)
            clip = 12'h7ff;
         else if (sum < -16'sh0800)
            clip = 12'h800;
      end else begin
         if (sum < 16'sh0000)
            clip = 12'h000;
         else if (sum > 16'sh0fff)
            clip = 12'hfff;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_r  <= 1'b0;
         result_r <= 12'h000;
      end else begin
         valid_r <= start;
         if (start)
            result_r <= clip;
      end
   end
endmodule // cal_unit
`default_nettype wire

// >>> testbench.sv
/*
 Self-checking testbench of the converter register interface.
 Assumes adc_regs with zero-wait APB and default timing div 2, acq 8.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_map.vh"
module testbench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0;
   logic        convst_pin = 0, timer0_evt = 0, timer1_evt = 0, logic_evt = 0, pwm_evt = 0;
   logic [11:0] sample_code = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, sample_hold_r, conversion_active_output_r, p0_2_r, irq_r;
   wire  [15:0] converter_control_r;
   wire  [4:0]  pos_sel, neg_sel, amp0, amp1;
   int          miscompares = 0, checks_done = 0, cycles = 0;
   localparam int conv_len = ((2 << 2) + 19) * (1 << 1);
   adc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convst_pin(convst_pin), .timer0_evt(timer0_evt), .timer1_evt(timer1_evt), .logic_evt(logic_evt),
      .pwm_evt(pwm_evt), .sample_code(sample_code), .sample_hold_r(sample_hold_r),
      .converter_control_r(converter_control_r), .positive_channel_select_r(pos_sel),
      .negative_channel_select_r(neg_sel), .front_amp_pair_zero_r(amp0), .front_amp_pair_one_r(amp1),
      .conversion_active_output_r(conversion_active_output_r), .p0_2_r(p0_2_r), .irq_r(irq_r));
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      // Request stands until pready is seen high at a rising edge, or 20 more edges pass
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge pclk);
      end
      if (k == 20)
         miscompares++;
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
   endtask
   task automatic rd(input logic [31:0] a, exp);
      logic [31:0] r;
      logic e;
      apb(0, a, 0, r, e);
      chk(r, exp);
   endtask
   task automatic conv(input logic [11:0] code, input logic irq_exp, p0_exp);
      int k, n;
      logic seen;
      wr(`CONTROL_ADDR, 32'h00000aa3);
      sample_code <= code;
      k = 0;
      while (conversion_active_output_r !== 1'b1 && k < 10) begin
         @(negedge pclk);
         k++;
      end
      n = 0;
      seen = 0;
      while (conversion_active_output_r === 1'b1 && n < 200) begin
         seen = seen | p0_2_r;
         n++;
         @(negedge pclk);
      end
      chk(32'(n), 32'(conv_len));
      chk({31'h0, seen}, {31'h0, p0_exp});
      repeat (4) @(negedge pclk);
      chk({31'h0, irq_r}, {31'h0, irq_exp});
   endtask
   task automatic t_reset_values();
      logic [31:0] r;
      logic e;
      rd(`CONTROL_ADDR, 32'h00000a00);
      rd(`STATUS_ADDR, 32'h0);
      apb(0, 32'hffff0600, 0, r, e);
      chk({31'h0, e}, 32'h1);
   endtask
   task automatic t_control_fields();
      logic [31:0] v;
      for (int m = 0; m < 3; m++)
         for (int t = 0; t < 7; t++) begin
            v = 32'h00000a00 | 32'(m << 3) | 32'(t);
            wr(`CONTROL_ADDR, v);
            rd(`CONTROL_ADDR, v);
         end
   endtask
   task automatic t_amp_gain();
      wr(`AMP_GAIN_ADDR, 32'h000002a3);
      @(negedge pclk);
      chk({22'h0, amp1, amp0}, 32'h000002a3);
   endtask
   task automatic t_single_conv();
      wr(`GPIO_CFG_ADDR, 32'h1);
      conv(12'h5a5, 1, 1);
      rd(`STATUS_ADDR, 32'h1);
      rd(`CONTROL_ADDR, 32'h00000aa0);
      rd(`RESULT_ADDR, 32'h05a50000);
      @(negedge pclk);
      @(negedge pclk);
      chk({31'h0, irq_r}, 32'h0);
      rd(`STATUS_ADDR, 32'h0);
   endtask
   task automatic t_calibration();
      wr(`OFFSET_CAL_ADDR, 32'h010);
      wr(`GAIN_CAL_ADDR, 32'h4000);
      wr(`POS_CHAN_ADDR, 32'h06);
      conv(12'h5a5, 1, 1);
      rd(`RESULT_ADDR, 32'h02e20000);
      wr(`POS_CHAN_ADDR, 32'h00);
      conv(12'h5a5, 1, 1);
      rd(`RESULT_ADDR, 32'h05b50000);
   endtask
   task automatic t_irq_mask();
      wr(`IRQ_ENABLE_ADDR, 32'h0);
      conv(12'h123, 0, 1);
      rd(`STATUS_ADDR, 32'h1);
      rd(`IRQ_STATUS_ADDR, 32'h1);
      wr(`IRQ_CLEAR_ADDR, 32'h1);
      rd(`STATUS_ADDR, 32'h0);
      wr(`IRQ_ENABLE_ADDR, 32'h1);
   endtask
   task automatic t_reg_reset();
      wr(`REG_RESET_ADDR, 32'h1);
      rd(`CONTROL_ADDR, 32'h00000a00);
      rd(`GAIN_CAL_ADDR, 32'h00008000);
      chk({22'h0, amp1, amp0}, 32'h0);
      // Port routing lives outside the converter registers and survives
      conv(12'h7ff, 1, 1);
      rd(`RESULT_ADDR, 32'h07ff0000);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      t_reset_values();
      t_control_fields();
      t_amp_gain();
      t_single_conv();
      t_calibration();
      t_irq_mask();
      t_reg_reset();
      summarize();
   end
endmodule // testbench
`default_nettype wire
